// >>> purge_timer.v
// Countdown timer that holds the post-unwrap purge state
`timescale 1ns/1ps
module purge_timer #(
  parameter CW = 24
) (
  input wire clk,
  input wire srst,
  input wire start,
  input wire [CW-1:0] load_value,
  output wire active,
  output reg [CW-1:0] count_q
);

  reg [CW-1:0] count_d;

  // A restart during a running purge reloads the full length
  always @* begin
    count_d = count_q;
    if (start) begin
      count_d = load_value;
    end else if (count_q != {CW{1'b0}}) begin
      count_d = count_q - {{(CW-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      count_q <= {CW{1'b0}};
    end else begin
      count_q <= count_d;
    end
  end

  assign active = (count_q != {CW{1'b0}});

endmodule

// >>> ring_neighbor.sv
// Downstream neighbour station that takes headers, promptly or slowly
`timescale 1ns/1ps
module ring_neighbor (
  input wire clk,
  input wire srst,
  input wire slow,
  output reg tx_ready
);
  // Slow mode refuses every other cycle so held outputs get exercised
  always @(posedge clk) begin
    if (srst) begin
      tx_ready <= 1'b0;
    end else begin
      tx_ready <= slow ? ~tx_ready : 1'b1;
    end
  end
endmodule

// >>> strict_wrap_filter.v
// Strict-order wrap eligibility, hop-limit handling and unwrap purge
//
// Behaviour
// - Launched frames leave with marker cleared
// - Primary-to-secondary wrap needs permit, clear marker, match
// - Source station sets marker on secondary pass
// - Secondary-to-primary wrap needs permit and marker
// - Hop limit decremented once on first wrap
// - Hop limit unchanged while on secondary ringlet
// - Normal decrement resumes after wrap back
// - Stranded secondary frames dropped without protection event
// - After unwrap drop mismatched strict frames everywhere
// - Purge persists for set duration
// - Queue purge until read reaches captured pointer
// - Arriving mismatched strict frames dropped during purge
// - Purge length timed, fifteen ms default
// - Rewrap during purge may lose, never reorder
// - Strict only when ordering flag is one
//
// Register access over Avalon-MM and the register offsets were decided locally.
`timescale 1ns/1ps
`include "strict_wrap_regs.vh"
module strict_wrap_filter #(
  parameter HW = 8,
  parameter PW = 8,
  parameter TW = 24,
  parameter [TW-1:0] PURGE_LEN = `PURGE_CYCLES
) (
  input wire clk,
  input wire srst,
  // Avalon-MM slave
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  // Protection context from the station
  input wire unwrap_event,
  input wire protect_active,
  input wire wrap_here,
  // Frame header stream in
  input wire rx_valid,
  output wire rx_ready,
  input wire rx_local_add,
  input wire rx_traveled,
  input wire rx_ringlet_ident,
  input wire rx_data_frame,
  input wire rx_ordering_strict_flag,
  input wire rx_wrap_permit_bit,
  input wire rx_past_origin_marker,
  input wire rx_source_here,
  input wire [HW-1:0] rx_hop_limit,
  // Frame header stream out
  output wire tx_valid,
  input wire tx_ready,
  output reg tx_ringlet_out_q,
  output reg tx_ringlet_ident_q,
  output reg tx_past_origin_marker_q,
  output reg tx_wrapped_q,
  output reg [HW-1:0] tx_hop_limit_q,
  output reg drop_pulse_q,
  // Secondary transit queue read-side check
  input wire [PW-1:0] stq_wr_ptr,
  input wire [PW-1:0] stq_rd_ptr,
  input wire stq_rd_valid,
  input wire stq_rd_strict,
  input wire stq_rd_data_frame,
  input wire stq_rd_ringlet_ident,
  input wire stq_rd_traveled,
  output wire stq_rd_discard
);

  reg ack_q;
  reg [31:0] ctrl_q;
  reg [TW-1:0] purge_len_q;
  reg [31:0] drop_cnt_q;
  reg [PW-1:0] mark_q;
  reg queue_purge_q;
  reg queue_purge_d;
  reg tx_valid_q;
  reg drop_d;
  reg pass_d;
  reg ringlet_out_d;
  reg marker_d;
  reg wrapped_d;
  reg [HW-1:0] hop_d;
  wire bus_req;
  wire wr_take;
  wire rd_take;
  wire sw_unwrap;
  wire unwrap_any;
  wire purge_active;
  wire purge_en;
  wire rx_take;
  wire on_primary;
  wire rx_strict;
  wire rx_mismatch;
  wire hop_zero;
  wire [TW-1:0] timer_count;
  wire [HW-1:0] hop_dec;

  // Bus: one wait cycle, request taken on the second edge
  assign bus_req = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack_q;
  assign wr_take = avs_write & ack_q;
  assign rd_take = avs_read & ack_q;

  always @(posedge clk) begin
    if (srst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req & ~ack_q;
    end
  end

  assign purge_en = ctrl_q[`CTRL_PURGE_EN_BIT];
  assign sw_unwrap = wr_take && (avs_address == `REG_CTRL_ADDR) &&
                     avs_writedata[`CTRL_SW_UNWRAP_BIT];
  // Software and protection logic may both start the purge
  assign unwrap_any = purge_en & (unwrap_event | sw_unwrap);

  always @(posedge clk) begin
    if (srst) begin
      ctrl_q <= `CTRL_RESET;
      purge_len_q <= PURGE_LEN;
    end else if (wr_take) begin
      if (avs_address == `REG_CTRL_ADDR) begin
        // Unwrap request bit is a strobe and is not stored
        ctrl_q <= {31'h0000_0000, avs_writedata[`CTRL_PURGE_EN_BIT]};
      end else if (avs_address == `REG_PURGE_LEN_ADDR) begin
        purge_len_q <= avs_writedata[TW-1:0];
      end
    end
  end

  // Read data is loaded on the wait cycle so it stands at the accepting edge
  always @(posedge clk) begin
    if (srst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & ~ack_q) begin
      if (avs_address == `REG_CTRL_ADDR) begin
        avs_readdata <= ctrl_q;
      end else if (avs_address == `REG_PURGE_LEN_ADDR) begin
        avs_readdata <= {{(32-TW){1'b0}}, purge_len_q};
      end else if (avs_address == `REG_STATUS_ADDR) begin
        avs_readdata <= {29'h0000_0000, protect_active, queue_purge_q,
                         purge_active};
      end else if (avs_address == `REG_DROP_CNT_ADDR) begin
        avs_readdata <= drop_cnt_q;
      end else begin
        avs_readdata <= 32'h0000_0000;
      end
    end
  end

  // Purge window, restarted by every unwrap
  purge_timer #(
    .CW(TW)
  ) u_timer (
    .clk(clk),
    .srst(srst),
    .start(unwrap_any),
    .load_value(purge_len_q),
    .active(purge_active),
    .count_q(timer_count)
  );

  // Transit queue: capture the write pointer, purge until read reaches it
  always @* begin
    queue_purge_d = queue_purge_q;
    if (queue_purge_q && stq_rd_ptr == mark_q) begin
      queue_purge_d = 1'b0;
    end
    if (unwrap_any) begin
      queue_purge_d = 1'b1; // new unwrap wins over the end
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      queue_purge_q <= 1'b0;
      mark_q <= {PW{1'b0}};
    end else begin
      queue_purge_q <= queue_purge_d;
      if (unwrap_any) begin
        mark_q <= stq_wr_ptr;
      end
    end
  end

  // Queue entries are checked against the ringlet they travel
  assign stq_rd_discard = stq_rd_valid & stq_rd_data_frame &
                          stq_rd_strict &
                          (stq_rd_ringlet_ident != stq_rd_traveled) &
                          (queue_purge_q | purge_active);

  // Arriving frame classification
  assign on_primary = (rx_ringlet_ident == rx_traveled);
  assign rx_strict = rx_data_frame & rx_ordering_strict_flag;
  assign rx_mismatch = ~on_primary;
  assign hop_zero = (rx_hop_limit == {HW{1'b0}});
  assign hop_dec = rx_hop_limit - {{(HW-1){1'b0}}, 1'b1};

  always @* begin
    drop_d = 1'b0;
    ringlet_out_d = rx_traveled;
    marker_d = rx_past_origin_marker;
    wrapped_d = 1'b0;
    hop_d = rx_hop_limit;
    if (rx_local_add) begin
      marker_d = 1'b0;
    end else if (purge_active && rx_strict && rx_mismatch) begin
      // Rewrapped frames are lost here rather than reordered
      drop_d = 1'b1;
    end else if (wrap_here && on_primary) begin
      if (rx_wrap_permit_bit && !rx_past_origin_marker && !hop_zero) begin
        ringlet_out_d = ~rx_traveled;
        wrapped_d = 1'b1;
        hop_d = hop_dec;
      end else begin
        drop_d = 1'b1;
      end
    end else if (wrap_here) begin
      if (rx_wrap_permit_bit && rx_past_origin_marker && !hop_zero) begin
        ringlet_out_d = ~rx_traveled;
        wrapped_d = 1'b1;
        hop_d = hop_dec;
      end else begin
        drop_d = 1'b1;
      end
    end else if (rx_mismatch) begin
      if (!protect_active) begin
        drop_d = 1'b1;
      end else if (rx_source_here) begin
        marker_d = 1'b1;
      end
    end else if (hop_zero) begin
      drop_d = 1'b1;
    end else begin
      hop_d = hop_dec;
    end
    pass_d = ~drop_d;
  end

  // One output stage; a stalled output holds the input back
  assign rx_ready = ~tx_valid_q | tx_ready;
  assign rx_take = rx_valid & rx_ready;
  assign tx_valid = tx_valid_q;

  always @(posedge clk) begin
    if (srst) begin
      tx_valid_q <= 1'b0;
      tx_ringlet_out_q <= 1'b0;
      tx_ringlet_ident_q <= 1'b0;
      tx_past_origin_marker_q <= 1'b0;
      tx_wrapped_q <= 1'b0;
      tx_hop_limit_q <= {HW{1'b0}};
      drop_pulse_q <= 1'b0;
    end else begin
      drop_pulse_q <= rx_take & drop_d;
      if (rx_take) begin
        tx_valid_q <= pass_d;
        tx_ringlet_out_q <= ringlet_out_d;
        tx_ringlet_ident_q <= rx_ringlet_ident;
        tx_past_origin_marker_q <= marker_d;
        tx_wrapped_q <= wrapped_d;
        tx_hop_limit_q <= hop_d;
      end else if (tx_ready) begin
        tx_valid_q <= 1'b0;
      end
    end
  end

  // Counts cycles with a stream drop or a queue discard; saturates rather than wraps
  always @(posedge clk) begin
    if (srst) begin
      drop_cnt_q <= `DROP_CNT_RESET;
    end else if (((rx_take & drop_d) | stq_rd_discard) &&
                 drop_cnt_q != 32'hffff_ffff) begin
      drop_cnt_q <= drop_cnt_q + 32'h0000_0001;
    end
  end

endmodule

// >>> strict_wrap_filter_sva.sv
// Port-level assertions for the strict wrap receive filter
`timescale 1ns/1ps
module strict_wrap_filter_sva #(parameter HW = 8) (
  input wire clk, srst, wrap_here, protect_active,
  input wire rx_valid, rx_ready, rx_local_add, rx_traveled,
  input wire rx_ringlet_ident, rx_data_frame, rx_ordering_strict_flag,
  input wire rx_wrap_permit_bit, rx_past_origin_marker, rx_source_here,
  input wire [HW-1:0] rx_hop_limit, tx_hop_limit_q,
  input wire tx_valid, tx_ready, tx_ringlet_out_q, tx_wrapped_q,
  input wire tx_past_origin_marker_q, drop_pulse_q,
  input wire stq_rd_valid, stq_rd_strict, stq_rd_data_frame,
  input wire stq_rd_ringlet_ident, stq_rd_traveled, stq_rd_discard
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  wire tk = rx_valid & rx_ready & ~rx_local_add;
  wire pri = rx_ringlet_ident == rx_traveled;
  wire sd = rx_data_frame & rx_ordering_strict_flag;
  wire hz = rx_hop_limit == 0;
  wire pm = rx_wrap_permit_bit;
  wire mk = rx_past_origin_marker;
  sequence s_dec;
    tx_valid && !drop_pulse_q && tx_hop_limit_q == $past(rx_hop_limit) - 1;
  endsequence
  sequence s_drop;
    drop_pulse_q && !tx_valid;
  endsequence
  a_local_clear: assert property (rx_valid && rx_ready && rx_local_add |=>
    tx_valid && !tx_past_origin_marker_q) else $error("launch marker set");
  a_wrap_out: assert property (tk && wrap_here && pri && pm && !mk && !hz
    |=> s_dec ##0 tx_wrapped_q && tx_ringlet_out_q != $past(rx_traveled))
    else $error("wrap out wrong");
  a_wrap_deny: assert property (tk && wrap_here && pri && !(pm && !mk)
    |=> s_drop) else $error("ineligible wrap not dropped");
  a_wrap_back: assert property (tk && wrap_here && !pri && !sd && pm && mk
    && !hz |=> s_dec) else $error("wrap back wrong");
  a_sec_keep: assert property (tk && !wrap_here && !pri && protect_active
    && !sd |=> tx_valid && tx_hop_limit_q == $past(rx_hop_limit) &&
    tx_past_origin_marker_q == ($past(mk) | $past(rx_source_here)))
    else $error("secondary forward wrong");
  a_strand_drop: assert property (tk && !wrap_here && !pri
    && !protect_active |=> s_drop) else $error("stranded frame kept");
  a_transit_dec: assert property (tk && !wrap_here && pri && !hz
    |=> s_dec) else $error("transit hop wrong");
  a_queue_cond: assert property (stq_rd_discard |-> stq_rd_valid &&
    stq_rd_strict && stq_rd_data_frame &&
    stq_rd_ringlet_ident != stq_rd_traveled) else $error("bad discard");
  a_out_hold: assert property (tx_valid && !tx_ready |=> tx_valid &&
    $stable(tx_hop_limit_q)) else $error("output not held");
endmodule
bind strict_wrap_filter strict_wrap_filter_sva #(.HW(HW)) u_sva (.*);

// >>> strict_wrap_filter_tb_top.sv
// Self-checking testbench for the strict wrap receive filter
`timescale 1ns/1ps
module strict_wrap_filter_tb_top;
  reg clk, srst, slow, avs_read, avs_write, unwrap_event;
  reg protect_active, wrap_here, rx_valid;
  reg [3:0] avs_address;
  reg [31:0] avs_writedata, rv;
  reg [7:0] f, rx_hop_limit, stq_wr_ptr, stq_rd_ptr;
  reg [4:0] q;
  wire rx_source_here = f[7], rx_past_origin_marker = f[6];
  wire rx_wrap_permit_bit = f[5], rx_ordering_strict_flag = f[4];
  wire rx_data_frame = f[3], rx_ringlet_ident = f[2];
  wire rx_traveled = f[1], rx_local_add = f[0];
  wire stq_rd_valid = q[4], stq_rd_strict = q[3], stq_rd_data_frame = q[2];
  wire stq_rd_ringlet_ident = q[1], stq_rd_traveled = q[0];
  wire [31:0] avs_readdata;
  wire [7:0] tx_hop_limit_q;
  wire avs_waitrequest, rx_ready, tx_valid, tx_ready, tx_ringlet_out_q;
  wire tx_ringlet_ident_q, tx_past_origin_marker_q, tx_wrapped_q;
  wire drop_pulse_q, stq_rd_discard;
  integer fail_count, comparisons;
  // Short purge keeps the run small; expectations use the same 20
  strict_wrap_filter #(.PURGE_LEN(24'd20)) i_dut (.*);
  ring_neighbor i_nb (.clk(clk), .srst(srst), .slow(slow),
    .tx_ready(tx_ready));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task end_sim;
    begin
      if (fail_count == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  task chk(input [31:0] s, input [31:0] e);
    begin
      comparisons = comparisons + 1;
      if (s !== e) begin
        fail_count = fail_count + 1;
        $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
    end
  endtask
  task tmo(input integer n);
    if (n >= 50) begin
      fail_count = fail_count + 1;
      end_sim;
    end
  endtask
  task acc(input w, input [3:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= ~w;
      avs_write <= w;
      n = 0;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0 && n < 50) begin
        @(posedge clk);
        n = n + 1;
      end
      tmo(n);
      rv = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask
  // e packs valid, drop, ringlet out, marker, hop; 12'h400 means drop
  task ex(input [7:0] v, input [7:0] h, input [11:0] e);
    integer n;
    begin
      @(posedge clk);
      f <= v;
      rx_hop_limit <= h;
      rx_valid <= 1'b1;
      n = 0;
      @(posedge clk);
      while (rx_ready !== 1'b1 && n < 50) begin
        @(posedge clk);
        n = n + 1;
      end
      tmo(n);
      rx_valid <= 1'b0;
      #1;
      if (e == 12'h400) chk({tx_valid, drop_pulse_q}, 32'h1);
      else chk({tx_valid, drop_pulse_q, tx_ringlet_out_q,
        tx_past_origin_marker_q, tx_hop_limit_q}, e);
    end
  endtask
  initial begin
    fail_count = 0;
    comparisons = 0;
    srst = 1'b1;
    {slow, avs_read, avs_write, unwrap_event, protect_active} = 5'h00;
    {wrap_here, rx_valid, avs_address, q} = 11'h000;
    {avs_writedata, f, rx_hop_limit, stq_wr_ptr, stq_rd_ptr} = 64'h0;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    acc(0, 4'h0, 0); chk(rv, 32'h1);
    acc(0, 4'hc, 0); chk(rv, 32'h0);
    acc(0, 4'h2, 0); chk(rv, 32'h0);
    acc(1, 4'h4, 32'd20); acc(0, 4'h4, 0); chk(rv, 32'd20);
    protect_active <= 1'b1;
    wrap_here <= 1'b1;
    ex(8'h38, 8'd5, 12'ha04);
    chk({tx_wrapped_q, tx_ringlet_ident_q}, 32'h2);
    ex(8'h78, 8'd5, 12'h400);
    ex(8'h6c, 8'd6, 12'hb05);
    wrap_here <= 1'b0;
    ex(8'hac, 8'd7, 12'h907);
    chk({tx_wrapped_q, tx_ringlet_ident_q}, 32'h1);
    slow <= 1'b1;
    ex(8'h08, 8'd3, 12'h802);
    ex(8'h49, 8'd9, 12'h809);
    slow <= 1'b0;
    protect_active <= 1'b0;
    ex(8'h0c, 8'd4, 12'h400);
    acc(0, 4'hc, 0); chk(rv, 32'h2);
    protect_active <= 1'b1;
    stq_wr_ptr <= 8'h05;
    @(posedge clk) unwrap_event <= 1'b1;
    @(posedge clk) unwrap_event <= 1'b0;
    ex(8'h1c, 8'd4, 12'h400);
    ex(8'h0c, 8'd4, 12'h804);
    q <= 5'b11110;
    #1 chk(stq_rd_discard, 32'h1);
    q <= 5'b11010;
    #1 chk(stq_rd_discard, 32'h0);
    acc(0, 4'h8, 0); chk(rv, 32'h7);
    stq_rd_ptr <= 8'h05;
    q <= 5'b00000;
    repeat (25) @(posedge clk);
    acc(0, 4'h8, 0); chk(rv, 32'h4);
    ex(8'h1c, 8'd4, 12'h804);
    end_sim;
  end
endmodule

// >>> strict_wrap_regs.vh
// Register map, field positions, reset values and timing for the filter
`ifndef STRICT_WRAP_REGS_VH
`define STRICT_WRAP_REGS_VH

// Word offsets on the register bus (byte addresses)
`define REG_CTRL_ADDR 4'h0
`define REG_PURGE_LEN_ADDR 4'h4
`define REG_STATUS_ADDR 4'h8
`define REG_DROP_CNT_ADDR 4'hc

// Control register fields
`define CTRL_PURGE_EN_BIT 0
`define CTRL_SW_UNWRAP_BIT 1
`define CTRL_RESET 32'h0000_0001

// Status register fields
`define STAT_PURGE_ACTIVE_BIT 0
`define STAT_QUEUE_PURGE_BIT 1
`define STAT_PROTECT_BIT 2

// Purge duration: time in microseconds, clock in MHz
`define PURGE_TIME_US 15000
`define CLK_FREQ_MHZ 25
`define PURGE_CYCLES (`PURGE_TIME_US * `CLK_FREQ_MHZ)

`define DROP_CNT_RESET 32'h0000_0000

`endif
